// File: hdl/tmc_timer.sv
// sixteen bit timer counter with AHB-Lite register slave
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module tmc_timer
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic [31:0] HRDATA,
  output var  logic        HREADYOUT,
  output var  logic        HRESP,
  // count sources and gate
  input  wire logic        EXT_COUNT_CLK,
  input  wire logic        TSO_CLK,
  input  wire logic        GATE_IN,
  input  wire logic        SLEEP,
  // results
  output var  logic [15:0] TIME_BASE,
  output var  logic        OVF_PULSE,
  output var  logic        WAKE,
  output var  logic        IRQ
);
  import tmc_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic [1:0]  div;
    logic [7:0]  tctl;
    logic [7:0]  gctl;
    logic        sts;
    logic        msk;
    logic        dph_wr;
    logic [7:0]  dph_adr;
    logic [31:0] rdata;
    logic        ovf;
    logic        wake;
    logic        irq;
    logic        rdy;
    logic        resp;
  } tmc_state_t;

  tmc_state_t st_r;
  tmc_state_t st_nxt;

  logic       ext_rise;
  logic       tso_rise;
  logic       on_bit;
  logic       byp_bit;
  logic [1:0] cs_fld;
  logic [1:0] ps_fld;
  logic       ge_bit;
  logic       addr_ok;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_cnt;
  logic       src_tick;
  logic       run_ok;
  logic       cnt_tick;
  logic       pre_pass;
  logic [2:0] pre_mask;
  logic       wrap;

  // external pin path; bypass skips the two synchroniser stages and also keeps external counting on in sleep
  tmc_edge_sync u_ext_sync
  (
    .clk    (CLK),
    .rst_n  (RST_N),
    .pin    (EXT_COUNT_CLK),
    .bypass (byp_bit),
    .rise   (ext_rise)
  );

  // sense oscillator is always resynchronised
  tmc_edge_sync u_tso_sync
  (
    .clk    (CLK),
    .rst_n  (RST_N),
    .pin    (TSO_CLK),
    .bypass (1'b0),
    .rise   (tso_rise)
  );

  // control field decode
  assign on_bit   = st_r.tctl[TCTL_ON];
  assign byp_bit  = st_r.tctl[TCTL_BYP];
  assign ps_fld   = st_r.tctl[TCTL_PS_LO +: 2];
  assign cs_fld   = st_r.tctl[TCTL_CS_LO +: 2];
  assign ge_bit   = st_r.gctl[GCTL_GE];
  assign addr_ok  = HSEL & HTRANS[1] & HREADY;
  assign wr_lo    = st_r.dph_wr & (st_r.dph_adr == ADR_CNT_LO);
  assign wr_hi    = st_r.dph_wr & (st_r.dph_adr == ADR_CNT_HI);
  assign wr_cnt   = wr_lo | wr_hi;

  // source tick pick; internal clocks stop in sleep, async external does not
  always_comb
  begin
    src_tick = 1'b0;
    case (cs_fld)
      CS_INSTR: src_tick = (st_r.div == DIV_LAST) & ~SLEEP;
      CS_SYS:   src_tick = ~SLEEP;
      CS_EXT:   src_tick = ext_rise & (byp_bit | ~SLEEP);
      CS_TSO:   src_tick = tso_rise & ~SLEEP;
      default:  src_tick = 1'b0;
    endcase
  end

  // enable: off when on bit clear, gate only matters with gate enable set
  assign run_ok   = on_bit & (~ge_bit | GATE_IN);
  assign pre_mask = 3'((4'h1 << ps_fld) - 4'h1);
  assign pre_pass = (st_r.pre & pre_mask) == pre_mask;
  assign cnt_tick = run_ok & src_tick & pre_pass & ~wr_cnt;
  assign wrap     = cnt_tick & (st_r.cnt == CNT_ALL1);

  // next state of the whole block
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.div = st_r.div + DIV_ONE;
    // zero wait state slave, always okay; hsize is ignored, every access is a word
    st_nxt.rdy  = 1'b1;
    st_nxt.resp = 1'b0;
    // prescaler advances on each enabled source tick, a count write clears it
    if (wr_cnt)
      st_nxt.pre = PRE_RST;
    else if (run_ok & src_tick)
      st_nxt.pre = st_r.pre + PRE_ONE;
    // counter; a write wins over the same-cycle increment, no contention merge
    if (wr_lo)
      st_nxt.cnt[7:0] = HWDATA[7:0];
    else if (wr_hi)
      st_nxt.cnt[15:8] = HWDATA[7:0];
    else if (cnt_tick)
      st_nxt.cnt = st_r.cnt + CNT_ONE;
    st_nxt.ovf = wrap;
    // wake is a level held for the rest of sleep
    if (!SLEEP)
      st_nxt.wake = 1'b0;
    else if (wrap & byp_bit & (cs_fld == CS_EXT))
      st_nxt.wake = 1'b1;
    // register writes in the data phase
    if (st_r.dph_wr)
    begin
      if (st_r.dph_adr == ADR_TCTL)
        st_nxt.tctl = HWDATA[7:0];
      else if (st_r.dph_adr == ADR_GCTL)
        st_nxt.gctl = HWDATA[7:0] & (8'h01 << GCTL_GE);
      else if (st_r.dph_adr == ADR_MASK)
        st_nxt.msk = HWDATA[STS_OVF];
    end
    // sticky overflow: write one clears, a new overflow wins over the clear
    if (wrap)
      st_nxt.sts = 1'b1;
    else if (st_r.dph_wr & (st_r.dph_adr == ADR_STATUS) & HWDATA[STS_OVF])
      st_nxt.sts = 1'b0;
    st_nxt.irq = st_nxt.sts & st_nxt.msk;
    // address phase capture; read data is loaded now and shown next cycle
    st_nxt.dph_wr  = addr_ok & HWRITE;
    st_nxt.dph_adr = HADDR[7:0];
    st_nxt.rdata   = '0;
    if (addr_ok & ~HWRITE & (HADDR[31:8] == 24'h000000))
    begin
      if (HADDR[7:0] == ADR_CNT_LO)
        st_nxt.rdata[7:0] = st_r.cnt[7:0];
      else if (HADDR[7:0] == ADR_CNT_HI)
        st_nxt.rdata[7:0] = st_r.cnt[15:8];
      else if (HADDR[7:0] == ADR_TCTL)
        st_nxt.rdata[7:0] = st_r.tctl;
      else if (HADDR[7:0] == ADR_GCTL)
        st_nxt.rdata[7:0] = st_r.gctl;
      else if (HADDR[7:0] == ADR_STATUS)
        st_nxt.rdata[STS_OVF] = st_r.sts;
      else if (HADDR[7:0] == ADR_MASK)
        st_nxt.rdata[STS_OVF] = st_r.msk;
    end
    if (addr_ok & HWRITE & (HADDR[31:8] != 24'h000000))
      st_nxt.dph_wr = 1'b0; // unmapped writes are dropped
  end

  // state register
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r      <= '0;
      st_r.cnt  <= CNT_RST;
      st_r.pre  <= PRE_RST;
      st_r.tctl <= TCTL_RST;
      st_r.gctl <= GCTL_RST;
      st_r.rdy  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from state flops
  assign HREADYOUT = st_r.rdy;
  assign HRESP     = st_r.resp;
  assign HRDATA    = st_r.rdata;
  assign TIME_BASE = st_r.cnt;
  assign OVF_PULSE = st_r.ovf;
  assign WAKE      = st_r.wake;
  assign IRQ       = st_r.irq;

  // off means frozen apart from writes
  a_off_frozen: assert property (@(posedge CLK) disable iff (!RST_N)
    (!on_bit && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("counter moved while off");

  // low byte write lands next cycle, high byte kept
  a_low_write: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_lo |=> (st_r.cnt[7:0] == $past(HWDATA[7:0])) && (st_r.cnt[15:8] == $past(st_r.cnt[15:8])))
    else $error("low byte write not applied");

  // high byte write lands next cycle
  a_high_write: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_hi |=> (st_r.cnt[15:8] == $past(HWDATA[7:0])))
    else $error("high byte write not applied");

  // prescaler cleared by count write
  a_pre_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_cnt |=> (st_r.pre == PRE_RST))
    else $error("prescaler not cleared");

  // system clock, ratio one, free run: one step a cycle
  a_sys_rate: assert property (@(posedge CLK) disable iff (!RST_N)
    (on_bit && !ge_bit && cs_fld == CS_SYS && ps_fld == 2'h0 && !wr_cnt && !SLEEP)
    |=> (st_r.cnt == $past(st_r.cnt) + CNT_ONE))
    else $error("system clock rate wrong");

  // instruction clock: no step unless divider at its last phase
  a_instr_div: assert property (@(posedge CLK) disable iff (!RST_N)
    (cs_fld == CS_INSTR && st_r.div != DIV_LAST && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("instruction clock stepped early");

  // ratio eight: at most one step in eight source ticks
  a_pre_eight: assert property (@(posedge CLK) disable iff (!RST_N)
    (ps_fld == 2'h3 && st_r.pre != 3'h7 && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("prescale by eight broken");

  // inactive gate holds the count
  a_gate_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (ge_bit && !GATE_IN && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("count moved with gate closed");

  // wrap makes exactly one overflow cycle and a zero count
  a_ovf_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    wrap |=> (OVF_PULSE && st_r.cnt == CNT_RST) ##1 !OVF_PULSE)
    else $error("overflow pulse wrong");

  // wake only from external asynchronous overflow in sleep
  a_wake_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(WAKE) |-> ($past(SLEEP) && $past(byp_bit) && $past(cs_fld) == CS_EXT && OVF_PULSE))
    else $error("wake without cause");

  // synchronous external path: pin rise reaches the counter three cycles on
  a_ext_sync: assert property (@(posedge CLK) disable iff (!RST_N)
    (cs_fld == CS_EXT && !byp_bit && ext_rise) |-> $past(EXT_COUNT_CLK, 3) == 1'b0 && $past(EXT_COUNT_CLK, 2))
    else $error("external edge not synchronised");

  // the counter only ever steps by one, writes aside
  a_step_one: assert property (@(posedge CLK) disable iff (!RST_N)
    !wr_cnt |=> ((st_r.cnt == $past(st_r.cnt)) || (st_r.cnt == $past(st_r.cnt) + CNT_ONE)))
    else $error("counter jumped");

  // external source: no pin edge, no step
  a_ext_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (cs_fld == CS_EXT && !ext_rise && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("external count without edge");

  // sense oscillator source: no resynchronised edge, no step
  a_tso_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (cs_fld == CS_TSO && !tso_rise && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("sense count without edge");

  // sleep freezes every source but the bypassed external pin
  a_sleep_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    (SLEEP && !(cs_fld == CS_EXT && byp_bit) && !wr_cnt) |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("counter ran in sleep");

  // bypass path counts on the raw pin rise itself
  a_byp_edge: assert property (@(posedge CLK) disable iff (!RST_N)
    (cs_fld == CS_EXT && byp_bit && ext_rise) |-> (EXT_COUNT_CLK && !$past(EXT_COUNT_CLK)))
    else $error("bypass edge wrong");

  // wake drops once the core is awake
  a_wake_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    !SLEEP |=> !WAKE)
    else $error("wake held while awake");

  // a wrap always leaves the status bit set
  a_wrap_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    wrap |=> st_r.sts)
    else $error("overflow status not set");
endmodule : tmc_timer
`default_nettype wire

// File: hdl/tmc_pkg.sv
// constants shared by the sixteen bit timer counter
// Notes on behaviour
// - counter is sixteen bits wide, seen by software as high and low byte
// - byte writes replace that counter byte immediately, no staging register
// - internal source 00 makes a timer advancing once per instruction cycle before prescale, 01 once per system clock
// - external source advances the counter on each rising external edge before prescale, outside sleep unless bypassed
// - on bit clear keeps the counter stopped regardless of gate enable
// - on bit set counts freely, or under gate control when gate enable set
// - select 11 sense oscillator, 01 system clock, 00 system clock over four
// - select 10 takes count clock from the external count clock pin
// - internal sources advance once per N periods, N set by prescaler
// - overflow wakes from sleep only with external clock and asynchronous operation
// - current counter value is driven to the capture compare unit
// - prescale field divides selected count clock by 1, 2, 4 or 8
// - prescaler is hidden from software and cleared by any count byte write
// - bypass bit skips external pin synchronisation and, with select 10, keeps the counter running in sleep
// - gated mode counts rising count edges while gate active, holds otherwise
package tmc_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_CNT_LO  = 8'h00;
  localparam logic [7:0] ADR_CNT_HI  = 8'h04;
  localparam logic [7:0] ADR_TCTL    = 8'h08;
  localparam logic [7:0] ADR_GCTL    = 8'h0C;
  localparam logic [7:0] ADR_STATUS  = 8'h10;
  localparam logic [7:0] ADR_MASK    = 8'h14;
  // timer control field positions
  localparam int TCTL_ON    = 0;
  localparam int TCTL_BYP   = 2;
  localparam int TCTL_PS_LO = 4;
  localparam int TCTL_CS_LO = 6;
  // gate control field position
  localparam int GCTL_GE    = 7;
  // status and mask bit
  localparam int STS_OVF    = 0;
  // clock select codes
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS   = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [1:0] CS_TSO   = 2'h3;
  // instruction clock is system clock over four
  localparam logic [1:0] DIV_LAST = 2'h3;
  // reset values and other constants
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0]  TCTL_RST = 8'h00;
  localparam logic [7:0]  GCTL_RST = 8'h00;
  localparam logic [2:0]  PRE_RST  = 3'h0;
  localparam logic [15:0] CNT_ALL1 = 16'hFFFF;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [2:0]  PRE_ONE  = 3'h1;
  localparam logic [1:0]  DIV_ONE  = 2'h1;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage : tmc_pkg

// File: hdl/tmc_edge_sync.sv
// count clock synchroniser with optional bypass and rising edge detector
`timescale 1ns/100ps
`default_nettype none
module tmc_edge_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // count clock in and control
  input  wire logic pin,
  input  wire logic bypass,
  // one cycle rise pulse
  output var  logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic raw_prev;
  } tmc_es_t;

  tmc_es_t st_r;
  tmc_es_t st_nxt;

  // first stage only feeds the second; bypass looks at the raw pin directly
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.s1       = pin;
    st_nxt.s2       = st_r.s1;
    st_nxt.s3       = st_r.s2;
    st_nxt.raw_prev = pin;
    rise = bypass ? (pin & ~st_r.raw_prev) : (st_r.s2 & ~st_r.s3);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule : tmc_edge_sync
`default_nettype wire

// File: dv/tmc_ahb_master.sv
// processor core model issuing single word AHB-Lite transfers
`timescale 1ns/100ps
`default_nettype none
module tmc_ahb_master
  import tmc_pkg::*;
(
  // clock
  input  wire logic        clk,
  // bus request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // bus answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // bus idle from time zero
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'hFFFFFFFF;
  end

  // one word transfer; released data shows inverted so stale data never looks valid
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
    hwdata <= ~wd;
  endtask : xfer
endmodule : tmc_ahb_master
`default_nettype wire

// File: dv/tmc_timer_tb_top.sv
// self checking bench for the timer counter
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_tb_top;
  import tmc_pkg::*;
  localparam logic [7:0] ADR_NONE = 8'h18;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel, hwrite, hrdy, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        ext_clk = 1'b0;
  logic        tso_clk = 1'b0;
  logic        gate_in = 1'b0;
  logic        sleep = 1'b0;
  logic [1:0]  src_cnt = 2'h0;
  logic [15:0] tbase;
  logic        ovf, wake, irq;
  int          fails = 0;
  int          tests_run = 0;

  // 125 MHz system clock
  always #4 clk = ~clk;

  // free running count sources, eight system clocks a period
  always @(posedge clk)
  begin
    src_cnt <= src_cnt + 2'h1;
    if (src_cnt == 2'h3)
    begin
      ext_clk <= ~ext_clk;
      tso_clk <= ~tso_clk;
    end
  end

  // design and processor model
  tmc_timer u_tmc_timer (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .EXT_COUNT_CLK(ext_clk), .TSO_CLK(tso_clk),
    .GATE_IN(gate_in), .SLEEP(sleep), .TIME_BASE(tbase), .OVF_PULSE(ovf), .WAKE(wake), .IRQ(irq));
  tmc_ahb_master u_tmc_ahb_master (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata));

  // comparison, bus and wait helpers
  task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : ck
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_tmc_ahb_master.xfer(1'b1, {24'h0, a}, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_tmc_ahb_master.xfer(1'b0, {24'h0, a}, 32'h0, d);
  endtask : rd

  // reset values, unmapped place ignored
  task automatic t_reset;
    logic [7:0]  adr [7] = '{ADR_CNT_LO, ADR_CNT_HI, ADR_TCTL, ADR_GCTL, ADR_STATUS, ADR_MASK, ADR_NONE};
    logic [31:0] v;
    wr(ADR_NONE, 32'hFFFFFFFF);
    foreach (adr[i])
    begin
      rd(adr[i], v);
      ck("reset read", 32'h0, v);
    end
    ck("resp", 32'h0, 32'(hresp));
    $display("test reset done");
  endtask : t_reset

  // byte writes land in the counter at once
  task automatic t_bytes;
    logic [31:0] v;
    wr(ADR_CNT_LO, 32'h5A);
    wr(ADR_CNT_HI, 32'hA5);
    cyc(1);
    ck("count", 32'hA55A, 32'(tbase));
    rd(ADR_CNT_HI, v);
    ck("high byte", 32'hA5, v);
    $display("test bytes done");
  endtask : t_bytes

  // every source and ratio over a 64 cycle window
  task automatic t_rates;
    logic [15:0] t0;
    int          per [5] = '{4, 1, 8, 8, 8};
    for (int j = 0; j < 5; j++)
      for (int p = 0; p < 4; p++)
      begin
        wr(ADR_TCTL, {24'h0, 2'(j > 3 ? 2 : j), 2'(p), 1'b0, 1'(j == 4), 2'h1});
        cyc(16);
        t0 = tbase;
        cyc(64);
        ck("rate", 32'(64 / (per[j] << p)), 32'(16'(tbase - t0)));
      end
    $display("test rates done");
  endtask : t_rates

  // gate holds and passes; off wins over gate
  task automatic t_gate;
    logic [15:0] t0;
    wr(ADR_GCTL, 32'h80);
    wr(ADR_TCTL, 32'h41);
    t0 = tbase;
    cyc(20);
    ck("gate low", 32'h0, 32'(16'(tbase - t0)));
    gate_in <= 1'b1;
    cyc(10);
    gate_in <= 1'b0;
    cyc(4);
    ck("gate high", 32'hA, 32'(16'(tbase - t0)));
    wr(ADR_TCTL, 32'h40);
    gate_in <= 1'b1;
    cyc(4);
    t0 = tbase;
    cyc(20);
    ck("off", 32'h0, 32'(16'(tbase - t0)));
    gate_in <= 1'b0;
    wr(ADR_GCTL, 32'h0);
    $display("test gate done");
  endtask : t_gate

  // prescaler restarts on a count write
  task automatic t_preclr;
    logic [15:0] v0;
    wr(ADR_TCTL, 32'h71);
    cyc(13);
    wr(ADR_CNT_LO, 32'h10);
    cyc(1);
    v0 = tbase;
    ck("low written", 32'h10, 32'(v0[7:0]));
    cyc(5);
    ck("held", 32'(v0), 32'(tbase));
    cyc(6);
    ck("stepped", 32'(v0 + 16'h1), 32'(tbase));
    $display("test prescale clear done");
  endtask : t_preclr

  // wrap pulse, sticky status, mask and clear
  task automatic t_ovf;
    logic [31:0] v;
    int          n;
    wr(ADR_TCTL, 32'h40);
    wr(ADR_CNT_LO, 32'hFE);
    wr(ADR_CNT_HI, 32'hFF);
    wr(ADR_MASK, 32'h1);
    wr(ADR_TCTL, 32'h41);
    n = 0;
    while (ovf !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    ck("pulse", 32'h1, 32'(ovf));
    ck("wrapped", 32'h0, 32'(tbase));
    ck("irq", 32'h1, 32'(irq));
    cyc(1);
    ck("pulse width", 32'h0, 32'(ovf));
    wr(ADR_TCTL, 32'h40);
    wr(ADR_MASK, 32'h0);
    cyc(1);
    ck("masked", 32'h0, 32'(irq));
    rd(ADR_STATUS, v);
    ck("sticky", 32'h1, v);
    wr(ADR_STATUS, 32'h1);
    rd(ADR_STATUS, v);
    ck("cleared", 32'h0, v);
    $display("test overflow done");
  endtask : t_ovf

  // sleep stops synced counting; bypass runs on and wakes
  task automatic t_sleep;
    int n;
    wr(ADR_CNT_LO, 32'hFE);
    wr(ADR_CNT_HI, 32'hFF);
    sleep <= 1'b1;
    wr(ADR_TCTL, 32'h81);
    cyc(64);
    ck("sleep hold", 32'hFFFE, 32'(tbase));
    ck("no wake", 32'h0, 32'(wake));
    wr(ADR_TCTL, 32'h85);
    n = 0;
    while (wake !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    ck("wake", 32'h1, 32'(wake));
    sleep <= 1'b0;
    cyc(3);
    ck("wake end", 32'h0, 32'(wake));
    wr(ADR_TCTL, 32'h0);
    $display("test sleep done");
  endtask : t_sleep

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // main sequence
  initial
  begin
    cyc(8);
    rst_n <= 1'b1;
    t_reset();
    t_bytes();
    t_rates();
    t_gate();
    t_preclr();
    t_ovf();
    t_sleep();
    wrap_up();
  end

  // watchdog against a hang
  initial
  begin
    cyc(20000);
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end
endmodule : tmc_timer_tb_top
`default_nettype wire
